// file: rtl/aab_pkg.sv
package aab_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets (byte addresses, one word each)
  localparam logic [11:0] OFS_CMD   = 12'h000; // write starts an operation
  localparam logic [11:0] OFS_WORK  = 12'h004; // work register
  localparam logic [11:0] OFS_STAT  = 12'h008; // flags
  localparam logic [3:0]  RPAGE_HI  = 4'h1;    // 0x100..0x1FC, 64 words
  localparam logic [5:0]  SPAGE_HI  = 6'h08;   // 0x200..0x23C, 16 words

  ////////////////////////////////////////////////////////////////////////////
  // page sizes
  localparam int unsigned RPAGE_DEPTH = 64;
  localparam int unsigned SPAGE_DEPTH = 16;
  localparam logic [5:0]  RPAGE_LAST  = 6'h3F;
  localparam logic [3:0]  SPAGE_LAST  = 4'hF;

  ////////////////////////////////////////////////////////////////////////////
  // status register bit positions
  localparam int unsigned STAT_Z  = 0;
  localparam int unsigned STAT_DC = 1;
  localparam int unsigned STAT_C  = 2;
  localparam int unsigned STAT_PD = 3; // halt_entered_flag
  localparam int unsigned STAT_TO = 4; // watchdog_expiry_flag

  ////////////////////////////////////////////////////////////////////////////
  // values after reset
  localparam logic [7:0]  WORK_RST = 8'h00;
  localparam logic        FLAG_RST = 1'b0;
  localparam logic        PD_RST   = 1'b1; // power-up reads 1
  localparam logic        TO_RST   = 1'b1; // power-up reads 1
  localparam logic [23:0] CMD_RST  = 24'h000000;

  ////////////////////////////////////////////////////////////////////////////
  // cycle counts
  localparam int unsigned OP_CYCLES  = 1; // every operation here
  localparam int unsigned RD_WAITS   = 1; // wait states on a bus read

  ////////////////////////////////////////////////////////////////////////////
  // operation codes
  typedef enum logic [3:0] {
    NOP_OP                    = 4'h0,
    REG_ADD_OP                = 4'h1,
    REG_ADD_WITH_CARRY_OP     = 4'h2,
    LITERAL_ADD_OP            = 4'h3,
    LITERAL_ADD_WITH_CARRY_OP = 4'h4,
    REG_AND_OP                = 4'h5,
    BIT_ZERO_OP               = 4'h6,
    WATCHDOG_RESTART_OP       = 4'h7,
    HALT_OP                   = 4'h8,
    SPAGE_WRITE_OP            = 4'h9,
    SPAGE_READ_OP             = 4'hA
  } aab_op_t;

  // command word, bits 23:0 of the write data
  typedef struct packed {
    logic [7:0] literal;
    logic [1:0] spare;
    logic [5:0] addr;
    logic [2:0] bit_sel;
    logic       dest;     // 0 work register, 1 addressed register
    aab_op_t    op;
  } aab_cmd_t;

  // adder result
  typedef struct packed {
    logic [7:0] sum;
    logic       nib_c;    // carry out of bit 3
    logic       c;        // carry out of bit 7
  } aab_sum_t;

  // bus slave states
  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_RD   = 1'b1
  } aab_bus_t;

endpackage : aab_pkg

// file: rtl/aab_adder.sv
`timescale 1ns/10ps
module aab_adder (
  input  wire logic [7:0]       a_i,
  input  wire logic [7:0]       b_i,
  input  wire logic             cin_i,
  output aab_pkg::aab_sum_t     res_o
);

  logic [4:0] low;
  logic [4:0] high;

  ////////////////////////////////////////////////////////////////////////////
  // two nibble adds so the digit carry falls out directly
  always_comb begin
    low  = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]} + {4'h0, cin_i};
    high = {1'b0, a_i[7:4]} + {1'b0, b_i[7:4]} + {4'h0, low[4]};
    res_o.sum   = {high[3:0], low[3:0]};
    res_o.nib_c = low[4];
    res_o.c     = high[4];
  end

endmodule : aab_adder

// file: rtl/aab_datapath.sv
`timescale 1ns/10ps
// Operation
// - for register add and register and, destination bit 0 writes the work register, 1 the addressed register
// - carry is 1 on add carry out of bit 7, else 0
// - register operands span 0x00 to 0x3F
// - special page spans 0x0 to 0xF
// - halt flag reads 1 after power-up or restart, 0 after halt
// - expiry flag 1 after power-up, restart or halt; 0 on timeout
// - register add with carry: reg plus work plus carry, flags, one cycle
// - register add: work plus reg, no carry-in, flags, one cycle
// - literal add with carry into work register, flags, one cycle
// - literal add into work register, no carry-in, flags, one cycle
// - register and to selected destination, zero flag only, one cycle
// - bit zero clears one bit 0..7, nothing else changes, one cycle
module aab_datapath (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  input  wire logic        wdt_timeout_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o
);

  logic [7:0]           rpage [aab_pkg::RPAGE_DEPTH];
  logic [7:0]           spage [aab_pkg::SPAGE_DEPTH];
  logic [7:0]           work;
  logic                 z;
  logic                 dc;
  logic                 c;
  logic                 pd;
  logic                 to;
  logic [23:0]          last_cmd;
  aab_pkg::aab_bus_t    bus_st;
  logic                 wr_pend;
  logic                 ph_ok;
  logic [11:0]          ph_addr;
  logic                 addr_take;
  logic                 bus_wr;
  logic                 sel_cmd;
  logic                 sel_work;
  logic                 sel_stat;
  logic                 sel_rpage;
  logic                 sel_spage;
  logic [5:0]           bus_ridx;
  logic [3:0]           bus_sidx;
  logic                 exec;
  aab_pkg::aab_cmd_t    cmd;
  logic [7:0]           opnd;
  logic                 is_lit;
  logic                 is_adc;
  logic [7:0]           add_b;
  aab_pkg::aab_sum_t    add_res;
  logic [7:0]           next_work;
  logic                 next_z;
  logic                 next_dc;
  logic                 next_c;
  logic                 next_pd;
  logic                 next_to;
  logic                 rp_we;
  logic [5:0]           rp_idx;
  logic [7:0]           rp_wdata;
  logic                 sp_we;
  logic [31:0]          rd_mux;

  ////////////////////////////////////////////////////////////////////////////
  // address phase: only taken while the bus is ready
  assign addr_take = hsel_i && htrans_i[1] && hready_i;

  // bus slave state; reads take one wait so write data of the
  // previous transfer is already visible in the answer
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      bus_st      <= aab_pkg::BUS_IDLE;
      wr_pend     <= 1'b0;
      ph_addr     <= 12'h000;
      ph_ok       <= 1'b0;
      hreadyout_o <= 1'b1;
    end else begin
      wr_pend <= addr_take && hwrite_i;
      if (addr_take) begin
        ph_addr <= haddr_i[11:0];
        ph_ok   <= (haddr_i[31:12] == 20'h00000);
      end
      case (bus_st)
        aab_pkg::BUS_IDLE: begin
          if (addr_take && !hwrite_i) begin
            bus_st      <= aab_pkg::BUS_RD;
            hreadyout_o <= 1'b0;
          end
        end
        aab_pkg::BUS_RD: begin
          bus_st      <= aab_pkg::BUS_IDLE;
          hreadyout_o <= 1'b1;
        end
        default: begin
          bus_st      <= aab_pkg::BUS_IDLE;
          hreadyout_o <= 1'b1;
        end
      endcase
    end
  end

  // response is always okay; unmapped reads give zero
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hresp_o <= 1'b0;
    end else begin
      hresp_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // data phase decode
  assign sel_cmd   = ph_ok && (ph_addr == aab_pkg::OFS_CMD);
  assign sel_work  = ph_ok && (ph_addr == aab_pkg::OFS_WORK);
  assign sel_stat  = ph_ok && (ph_addr == aab_pkg::OFS_STAT);
  assign sel_rpage = ph_ok && (ph_addr[11:8] == aab_pkg::RPAGE_HI);
  assign sel_spage = ph_ok && (ph_addr[11:6] == aab_pkg::SPAGE_HI);
  assign bus_ridx  = ph_addr[7:2];
  assign bus_sidx  = ph_addr[5:2];
  assign bus_wr    = wr_pend;

  // a command write executes in its own data phase cycle
  assign exec = bus_wr && sel_cmd;
  assign cmd  = aab_pkg::aab_cmd_t'(hwdata_i[23:0]);
  assign opnd = rpage[cmd.addr];

  ////////////////////////////////////////////////////////////////////////////
  // operand selection for the shared adder
  assign is_lit = (cmd.op == aab_pkg::LITERAL_ADD_OP) ||
                  (cmd.op == aab_pkg::LITERAL_ADD_WITH_CARRY_OP);
  assign is_adc = (cmd.op == aab_pkg::REG_ADD_WITH_CARRY_OP) ||
                  (cmd.op == aab_pkg::LITERAL_ADD_WITH_CARRY_OP);
  assign add_b  = is_lit ? cmd.literal : opnd;

  aab_adder u_adder (
    .a_i   (work),
    .b_i   (add_b),
    .cin_i (is_adc & c),
    .res_o (add_res)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state of work register, flags and page writes
  always_comb begin
    next_work = work;
    next_z    = z;
    next_dc   = dc;
    next_c    = c;
    next_pd   = pd;
    next_to   = to;
    rp_we     = 1'b0;
    rp_idx    = bus_ridx;
    rp_wdata  = hwdata_i[7:0];
    sp_we     = 1'b0;
    if (bus_wr && sel_work) begin
      next_work = hwdata_i[7:0];
    end
    if (bus_wr && sel_stat) begin
      next_z  = hwdata_i[aab_pkg::STAT_Z];
      next_dc = hwdata_i[aab_pkg::STAT_DC];
      next_c  = hwdata_i[aab_pkg::STAT_C];
    end
    if (bus_wr && sel_rpage) begin
      rp_we = 1'b1;
    end
    if (exec) begin
      rp_idx = cmd.addr;
      case (cmd.op)
        aab_pkg::REG_ADD_OP,
        aab_pkg::REG_ADD_WITH_CARRY_OP: begin
          next_z  = (add_res.sum == 8'h00);
          next_dc = add_res.nib_c;
          next_c  = add_res.c;
          if (cmd.dest) begin
            rp_we    = 1'b1;
            rp_wdata = add_res.sum;
          end else begin
            next_work = add_res.sum;
          end
        end
        aab_pkg::LITERAL_ADD_OP,
        aab_pkg::LITERAL_ADD_WITH_CARRY_OP: begin
          next_work = add_res.sum;
          next_z    = (add_res.sum == 8'h00);
          next_dc   = add_res.nib_c;
          next_c    = add_res.c;
        end
        aab_pkg::REG_AND_OP: begin
          next_z = ((work & opnd) == 8'h00);
          if (cmd.dest) begin
            rp_we    = 1'b1;
            rp_wdata = work & opnd;
          end else begin
            next_work = work & opnd;
          end
        end
        aab_pkg::BIT_ZERO_OP: begin
          rp_we    = 1'b1;
          rp_wdata = opnd & ~(8'h01 << cmd.bit_sel);
        end
        aab_pkg::WATCHDOG_RESTART_OP: begin
          next_pd = 1'b1;
          next_to = 1'b1;
        end
        aab_pkg::HALT_OP: begin
          next_pd = 1'b0;
          next_to = 1'b1;
        end
        aab_pkg::SPAGE_WRITE_OP: begin
          sp_we = 1'b1;
        end
        aab_pkg::SPAGE_READ_OP: begin
          next_work = spage[cmd.addr[3:0]];
        end
        default: begin
          next_work = work;
        end
      endcase
    end
    // expiry wins over a restart in the same cycle, the timeout is newer
    if (wdt_timeout_i) begin
      next_to = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // work register and flags
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      work <= aab_pkg::WORK_RST;
      z    <= aab_pkg::FLAG_RST;
      dc   <= aab_pkg::FLAG_RST;
      c    <= aab_pkg::FLAG_RST;
    end else begin
      work <= next_work;
      z    <= next_z;
      dc   <= next_dc;
      c    <= next_c;
    end
  end

  // power state flags, reset stands for power-up
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pd <= aab_pkg::PD_RST;
      to <= aab_pkg::TO_RST;
    end else begin
      pd <= next_pd;
      to <= next_to;
    end
  end

  // last command kept for read back
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      last_cmd <= aab_pkg::CMD_RST;
    end else if (exec) begin
      last_cmd <= hwdata_i[23:0];
    end
  end

  // page storage has no reset, contents start unknown
  always_ff @(posedge clk_i) begin
    if (rp_we) begin
      rpage[rp_idx] <= rp_wdata;
    end
    if (sp_we) begin
      spage[cmd.addr[3:0]] <= work;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data, loaded at the end of the wait cycle
  always_comb begin
    rd_mux = 32'h00000000;
    if (sel_cmd) begin
      rd_mux = {8'h00, last_cmd};
    end else if (sel_work) begin
      rd_mux = {24'h000000, work};
    end else if (sel_stat) begin
      rd_mux = {27'h0000000, to, pd, c, dc, z};
    end else if (sel_rpage) begin
      rd_mux = {24'h000000, rpage[bus_ridx]};
    end else if (sel_spage) begin
      rd_mux = {24'h000000, spage[bus_sidx]};
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hrdata_o <= 32'h00000000;
    end else if (bus_st == aab_pkg::BUS_RD) begin
      hrdata_o <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic [8:0] ref_sum;
  logic [4:0] ref_nib;
  logic [7:0] ref_reg;
  logic       reg_math;
  logic       is_add;

  always_comb begin
    ref_sum = {1'b0, work} + {1'b0, add_b} + {8'h00, is_adc & c};
    ref_nib = {1'b0, work[3:0]} + {1'b0, add_b[3:0]} + {4'h0, is_adc & c};
    ref_reg = (cmd.op == aab_pkg::REG_AND_OP) ? (work & opnd) : ref_sum[7:0];
  end
  assign is_add   = exec && (cmd.op inside {aab_pkg::REG_ADD_OP,
                    aab_pkg::REG_ADD_WITH_CARRY_OP, aab_pkg::LITERAL_ADD_OP,
                    aab_pkg::LITERAL_ADD_WITH_CARRY_OP});
  assign reg_math = exec && (cmd.op inside {aab_pkg::REG_ADD_OP,
                    aab_pkg::REG_ADD_WITH_CARRY_OP, aab_pkg::REG_AND_OP});

  sequence s_rd_req;
    hsel_i && htrans_i[1] && !hwrite_i && hready_i && hreadyout_o;
  endsequence
  sequence s_rd_answer;
    !hreadyout_o ##1 hreadyout_o && hrdata_o == $past(rd_mux);
  endsequence

  a_read_wait: assert property (s_rd_req |=> s_rd_answer)
    else $error("read answer not after one wait");
  a_dest_work: assert property (
    reg_math && !cmd.dest |=> work == $past(ref_reg))
    else $error("result not in work register");
  a_dest_reg: assert property (
    reg_math && cmd.dest |=> rpage[$past(cmd.addr)] == $past(ref_reg)
    && $stable(work))
    else $error("result not in addressed register");
  a_carry_out: assert property (
    is_add |=> c == $past(ref_sum[8]))
    else $error("carry flag wrong");
  a_page_write: assert property (
    bus_wr && sel_rpage |=> rpage[$past(bus_ridx)] == $past(hwdata_i[7:0]))
    else $error("register page write lost");
  a_spage_move: assert property (
    exec && cmd.op == aab_pkg::SPAGE_WRITE_OP
    |=> spage[$past(cmd.addr[3:0])] == $past(work))
    else $error("special page write lost");
  a_halt_flags: assert property (
    exec && cmd.op == aab_pkg::HALT_OP && !wdt_timeout_i |=> !pd && to)
    else $error("halt flags wrong");
  a_restart_flags: assert property (
    exec && cmd.op == aab_pkg::WATCHDOG_RESTART_OP |=> pd)
    else $error("restart did not set halt flag");
  a_timeout_clr: assert property (
    wdt_timeout_i |=> !to)
    else $error("timeout did not clear expiry flag");
  a_lit_add: assert property (
    is_add && is_lit |=> work == $past(ref_sum[7:0]))
    else $error("literal add result wrong");
  a_and_flags: assert property (
    exec && cmd.op == aab_pkg::REG_AND_OP
    |=> $stable(c) && $stable(dc) && z == ($past(ref_reg) == 8'h00))
    else $error("and flags wrong");
  a_bit_zero: assert property (
    exec && cmd.op == aab_pkg::BIT_ZERO_OP
    |=> rpage[$past(cmd.addr)] == $past(opnd & ~(8'h01 << cmd.bit_sel))
    && $stable({z, dc, c, work}))
    else $error("bit zero wrong");
  a_zero_flag: assert property (
    is_add |=> z == ($past(ref_sum[7:0]) == 8'h00) && dc == $past(ref_nib[4]))
    else $error("zero or digit carry wrong");

endmodule : aab_datapath

// file: test/aab_datapath_tb_top.sv
`timescale 1ns/10ps
module aab_datapath_tb_top;
  logic        clk_i         = 1'b0;
  logic        rst_i         = 1'b1;
  logic        hsel_i        = 1'b0;
  logic [31:0] haddr_i       = 32'h0;
  logic [1:0]  htrans_i      = 2'h0;
  logic        hwrite_i      = 1'b0;
  logic [2:0]  hsize_i       = 3'h2;
  logic [31:0] hwdata_i      = 32'h0;
  logic        wdt_timeout_i = 1'b0;
  logic [31:0] hrdata_o;
  logic        hreadyout_o;
  logic        hresp_o;
  int          mismatches    = 0;
  int          checked       = 0;
  integer      seed          = 32'hC2E886BB;
  logic [7:0]  work;
  logic [7:0]  page [64];
  logic [7:0]  spage [16];
  logic        zf, dcf, cf, pdf, tof;
  logic [31:0] rd;

  // 200 MHz core clock
  always #2.5 clk_i = ~clk_i;

  // single slave, so its ready is the bus ready
  aab_datapath DUT (
    .clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
    .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
    .wdt_timeout_i(wdt_timeout_i), .hrdata_o(hrdata_o),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o));

  ////////////////////////////////////////////////////////////////////////////
  // comparison and bus tasks
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_word

  // bounded wait so a stuck ready cannot hang the run
  task automatic wait_ready;
    int n;
    n = 0;
    @(posedge clk_i);
    while (hreadyout_o !== 1'b1 && n < 16) begin
      n++;
      @(posedge clk_i);
    end
    if (n == 16) cmp_word({31'h0, hreadyout_o}, 32'h1);
  endtask : wait_ready

  task automatic bus(input logic wr, input logic [31:0] a,
                     input logic [31:0] wd);
    hsel_i   <= 1'b1;
    haddr_i  <= a;
    hwrite_i <= wr;
    htrans_i <= 2'h2;
    hsize_i  <= 3'h2;
    wait_ready();
    htrans_i <= 2'h0;
    hwdata_i <= wr ? wd : $random(seed);
    wait_ready();
    rd = hrdata_o;
    cmp_word({31'h0, hresp_o}, 32'h0);
  endtask : bus

  task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    cmp_word(rd, exp);
  endtask : rdchk

  function automatic logic [31:0] rp(input logic [5:0] n);
    return {20'h0, aab_pkg::RPAGE_HI, n, 2'b00};
  endfunction : rp

  function automatic logic [31:0] sp(input logic [3:0] n);
    return {20'h0, aab_pkg::SPAGE_HI, n, 2'b00};
  endfunction : sp

  function automatic logic [31:0] stat_exp;
    return {27'h0, tof, pdf, cf, dcf, zf};
  endfunction : stat_exp

  // {carry, nibble carry, sum} of an 8-bit add
  function automatic logic [9:0] add_exp(input logic [7:0] a, b,
                                         input logic ci);
    logic [8:0] s;
    logic [4:0] n;
    s = {1'b0, a} + {1'b0, b} + {8'h0, ci};
    n = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
    return {s[8], n[4], s[7:0]};
  endfunction : add_exp

  ////////////////////////////////////////////////////////////////////////////
  // model update, then register writes (setup) or command write and read back of work, flags and operand (do_op)
  task automatic setup(input logic [7:0] w, input logic [5:0] ra,
                       input logic [7:0] rv, input logic [2:0] st);
    work     = w;
    page[ra] = rv;
    {cf, dcf, zf} = st;
    bus(1'b1, {20'h0, aab_pkg::OFS_WORK}, {24'h0, w});
    bus(1'b1, rp(ra), {24'h0, rv});
    bus(1'b1, {20'h0, aab_pkg::OFS_STAT}, {29'h0, st});
  endtask : setup

  task automatic do_op(input aab_pkg::aab_op_t op, input logic d,
                       input logic [5:0] ra, input logic [2:0] bn,
                       input logic [7:0] lit);
    aab_pkg::aab_cmd_t cmd;
    logic [9:0]        r;
    logic              lo;
    cmd = '{literal: lit, spare: 2'b00, addr: ra, bit_sel: bn, dest: d,
            op: op};
    lo = op inside {aab_pkg::LITERAL_ADD_OP,
                    aab_pkg::LITERAL_ADD_WITH_CARRY_OP};
    r = add_exp(work, lo ? lit : page[ra],
                op inside {aab_pkg::REG_ADD_WITH_CARRY_OP,
                           aab_pkg::LITERAL_ADD_WITH_CARRY_OP} ? cf : 1'b0);
    case (op)
      aab_pkg::REG_ADD_OP, aab_pkg::REG_ADD_WITH_CARRY_OP,
      aab_pkg::LITERAL_ADD_OP, aab_pkg::LITERAL_ADD_WITH_CARRY_OP: begin
        {cf, dcf} = r[9:8];
        zf = (r[7:0] == 8'h00);
        if (d && !lo) page[ra] = r[7:0];
        else work = r[7:0];
      end
      aab_pkg::REG_AND_OP: begin
        zf = ((work & page[ra]) == 8'h00);
        if (d) page[ra] = work & page[ra];
        else work = work & page[ra];
      end
      aab_pkg::BIT_ZERO_OP: page[ra][bn] = 1'b0;
      aab_pkg::WATCHDOG_RESTART_OP: {pdf, tof} = 2'b11;
      aab_pkg::HALT_OP: {pdf, tof} = 2'b01;
      aab_pkg::SPAGE_WRITE_OP: spage[ra[3:0]] = work;
      aab_pkg::SPAGE_READ_OP: work = spage[ra[3:0]];
      default: ;
    endcase
    bus(1'b1, {20'h0, aab_pkg::OFS_CMD}, {8'h00, cmd});
    rdchk({20'h0, aab_pkg::OFS_WORK}, {24'h0, work});
    rdchk({20'h0, aab_pkg::OFS_STAT}, stat_exp());
    rdchk(rp(ra), {24'h0, page[ra]});
  endtask : do_op

  task automatic wdt_pulse;
    wdt_timeout_i <= 1'b1;
    @(posedge clk_i);
    wdt_timeout_i <= 1'b0;
    tof = 1'b0;
    rdchk({20'h0, aab_pkg::OFS_STAT}, stat_exp());
  endtask : wdt_pulse

  task automatic final_report;
    $display("counts: checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report

  ////////////////////////////////////////////////////////////////////////////
  // watchdog: about 5k cycles expected, 40k allowed before giving up
  initial begin
    #200000;
    mismatches++;
    $display("MISMATCH at %0t: got %h expected %h", $time, 1'b0, 1'b1);
    final_report();
  end

  // main sequence
  initial begin
    aab_pkg::aab_op_t op;
    logic [5:0]       a;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    {work, zf, dcf, cf, pdf, tof} = {8'h00, 3'b000, 2'b11};
    @(posedge clk_i);
    rdchk({20'h0, aab_pkg::OFS_WORK}, 32'h0);
    rdchk({20'h0, aab_pkg::OFS_STAT}, stat_exp());
    $display("test reset done");
    // flag bits 3 and 4 must not follow a status write
    bus(1'b1, {20'h0, aab_pkg::OFS_STAT}, 32'h0000_0005);
    {cf, dcf, zf} = 3'b101;
    rdchk({20'h0, aab_pkg::OFS_STAT}, stat_exp());
    for (int i = 0; i < 64; i++) begin
      page[i] = 8'($random(seed));
      bus(1'b1, rp(i[5:0]), {24'h0, page[i]});
    end
    for (int i = 0; i < 64; i++) rdchk(rp(i[5:0]), {24'h0, page[i]});
    bus(1'b1, 32'h0000_0300, 32'h0000_00FF);
    rdchk(32'h0000_0300, 32'h0);
    rdchk(32'h0000_1004, 32'h0);
    $display("test pages done");
    // hand-picked edges: wrap to zero, nibble carry, carry in
    setup(8'h12, 6'h05, 8'h34, 3'b100);
    do_op(aab_pkg::REG_ADD_WITH_CARRY_OP, 1'b1, 6'h05, 3'h0, 8'h00);
    setup(8'hFF, 6'h3F, 8'h01, 3'b100);
    do_op(aab_pkg::REG_ADD_OP, 1'b0, 6'h3F, 3'h0, 8'h00);
    setup(8'h0F, 6'h00, 8'h00, 3'b000);
    do_op(aab_pkg::LITERAL_ADD_OP, 1'b1, 6'h00, 3'h0, 8'h01);
    setup(8'hFF, 6'h00, 8'h00, 3'b100);
    do_op(aab_pkg::LITERAL_ADD_WITH_CARRY_OP, 1'b0, 6'h00, 3'h0, 8'h00);
    setup(8'h5A, 6'h3F, 8'hA5, 3'b110);
    do_op(aab_pkg::REG_AND_OP, 1'b1, 6'h3F, 3'h0, 8'h00);
    setup(8'h00, 6'h3F, 8'hFF, 3'b111);
    do_op(aab_pkg::BIT_ZERO_OP, 1'b0, 6'h3F, 3'h7, 8'h00);
    $display("test corners done");
    // random operations, random flags set ahead of every fourth one
    for (int i = 0; i < 300; i++) begin
      op = aab_pkg::aab_op_t'(4'(1 + ($unsigned($random(seed)) % 6)));
      a  = 6'($random(seed));
      if (i % 4 == 0) begin
        setup(8'($random(seed)), a, 8'($random(seed)), 3'($random(seed)));
      end
      do_op(op, 1'($random(seed)), a, 3'($random(seed)),
            8'($random(seed)));
    end
    $display("test random done");
    for (int i = 0; i < 16; i++) begin
      setup(8'($random(seed)), 6'h01, page[1], {cf, dcf, zf});
      do_op(aab_pkg::SPAGE_WRITE_OP, 1'b0, {2'b00, i[3:0]}, 3'h0, 8'h00);
      rdchk(sp(i[3:0]), {24'h0, spage[i]});
    end
    for (int i = 15; i >= 0; i--) begin
      do_op(aab_pkg::SPAGE_READ_OP, 1'b0, {2'b00, i[3:0]}, 3'h0, 8'h00);
    end
    $display("test special page done");
    do_op(aab_pkg::HALT_OP, 1'b0, 6'h00, 3'h0, 8'h00);
    wdt_pulse();
    do_op(aab_pkg::WATCHDOG_RESTART_OP, 1'b0, 6'h00, 3'h0, 8'h00);
    wdt_pulse();
    do_op(aab_pkg::HALT_OP, 1'b0, 6'h00, 3'h0, 8'h00);
    $display("test halt and expiry flags done");
    // codes with no operation must leave work, flags and operand alone
    do_op(aab_pkg::NOP_OP, 1'b1, 6'h3F, 3'h5, 8'hFF);
    do_op(aab_pkg::aab_op_t'(4'hF), 1'b1, 6'h3F, 3'h5, 8'hFF);
    // reset in mid-run brings the halt and expiry flags back to 1
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    {work, zf, dcf, cf, pdf, tof} = {8'h00, 3'b000, 2'b11};
    @(posedge clk_i);
    rdchk({20'h0, aab_pkg::OFS_WORK}, 32'h0);
    rdchk({20'h0, aab_pkg::OFS_STAT}, stat_exp());
    $display("test mid-run reset done");
    final_report();
  end

endmodule : aab_datapath_tb_top
